// File: verilog/oig_pkg.sv
/*
 * Shared constants and carrier types for the interrupt enable gating stage.
 * Assumes one 250 MHz controller clock and a simple word-wide register port.
 */
package oig_pkg;

    // Register word geometry
    localparam int          OIG_DATA_W      = 32;
    localparam int          OIG_ADDR_W      = 8;

    // Offset of the enable register inside the function's memory window
    localparam logic [7:0]  OIG_ENABLE_OFS  = 8'h10;
    // Offset of the companion disable register, which reads back the enables
    localparam logic [7:0]  OIG_DISABLE_OFS = 8'h14;

    // Field positions
    localparam int          OIG_MASTER_BIT  = 31;
    localparam int          OIG_OWNER_BIT   = 30;
    localparam int          OIG_EVENT_TOP   = 6;

    // Implemented bits: master, ownership change and events 6..0
    localparam logic [31:0] OIG_IMPL_MASK   = 32'hC000_007F;
    // Event bits that the master gate controls
    localparam logic [31:0] OIG_EVENT_MASK  = 32'h4000_007F;
    // Reset value of the enable register
    localparam logic [31:0] OIG_ENABLE_RST  = 32'h0000_0000;

    // Register access request from the host-side decoder
    typedef struct packed {
        logic                  wr;
        logic                  rd;
        logic [OIG_ADDR_W-1:0] addr;
        logic [OIG_DATA_W-1:0] wdata;
    } oig_req_t;

    // Coupled write into the disable register
    typedef struct packed {
        logic                  wr;
        logic [OIG_DATA_W-1:0] wdata;
    } oig_dis_t;

endpackage

// File: verilog/oig_enable_gate.sv
/*
 * Interrupt enable register with set-on-one writes, clear through the
 * coupled disable register, and the gated interrupt request.
 * Assumes the status flags and disable writes come from logic on clk_in.
 */
// Function
// RULE1: Interrupt needs status, enable and master set
// RULE2: Written one sets the enable bit
// RULE3: Written zero leaves enable bit unchanged
// RULE4: Read returns present enable bits
// RULE5: Bit 31 is the master interrupt gate
// RULE6: Bit 30 enables ownership change interrupt
// RULE7: Bits 6..0 enable the seven frame events
// RULE8: Software writes reserved bits as zero
// RULE9: Enable register sits at offset 10h
// RULE10: Status flags set by hardware, cleared by software
// RULE11: Disable write of one clears enable bit
// RULE12: Interrupt request is a level
`timescale 1ns/10ps
module oig_enable_gate (
    // Clock and reset
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    // Register port
    input  wire oig_pkg::oig_req_t req_in,
    output logic [31:0]            rdata_out,
    // Coupling from the status and disable registers
    input  wire logic [31:0]       status_in,
    input  wire oig_pkg::oig_dis_t dis_in,
    // Results
    output logic [31:0]            enable_out,
    output logic                   irq_out
);
    import oig_pkg::*;

    // Timing at a glance
    // Write or disable strobe: effect on enable_out one edge later
    // Read strobe: rdata_out valid for exactly the following cycle
    // Request: follows the gated flags one cycle late, as a level
    // Status flags never written here, so a held flag holds the request
    // Set and clear of one bit together: the set is kept

    logic [31:0] en_q;            // Enable register
    logic [31:0] en_d;            // Its next value
    logic [31:0] rdata_q;         // Read data holding register
    logic [31:0] rdata_d;         // Next read data
    logic        irq_q;           // Registered request
    logic        irq_d;           // Next request level
    wire         hit_en;          // Access to the enable offset
    wire         hit_dis;         // Access to the disable offset
    wire  [31:0] set_bits;        // Bits set by this write
    wire  [31:0] clr_bits;        // Bits cleared by a disable write
    wire  [31:0] pending;         // Enabled events currently flagged

    // Address decode
    assign hit_en   = (req_in.addr == OIG_ENABLE_OFS);              // see RULE9
    assign hit_dis  = (req_in.addr == OIG_DISABLE_OFS);
    // Ones set, zeros ignored; reserved bits never stored
    assign set_bits = (req_in.wr && hit_en) ? (req_in.wdata & OIG_IMPL_MASK)
                                            : 32'h0000_0000;        // see RULE2 see RULE3 see RULE8
    // Ones on the disable port clear, zeros leave the bit alone
    assign clr_bits = dis_in.wr ? (dis_in.wdata & OIG_IMPL_MASK)
                                : 32'h0000_0000;                    // see RULE11
    // A set in the same cycle as a clear wins
    assign en_d     = (en_q & ~clr_bits) | set_bits;
    // Status flags are owned by the status register; only gated here
    assign pending  = status_in & en_q & OIG_EVENT_MASK;            // see RULE10 see RULE6 see RULE7
    // Master gate over the flagged events; status bit 31 has no event
    assign irq_d    = en_q[OIG_MASTER_BIT] && (|pending);           // see RULE1 see RULE5 see RULE12
    // Both offsets read back the enables; others read zero
    assign rdata_d  = (req_in.rd && (hit_en || hit_dis)) ? en_q
                                                         : 32'h0000_0000; // see RULE4

    // Enable register
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            en_q <= OIG_ENABLE_RST;
        end else begin
            en_q <= en_d;
        end
    end

    // Read data and request level
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_q <= 32'h0000_0000;
            irq_q   <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            irq_q   <= irq_d;
        end
    end

    assign rdata_out  = rdata_q;
    assign enable_out = en_q;
    assign irq_out    = irq_q;

    // Checks, all on the controller clock and quiet during reset
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    // Write strobe to the enable offset
    sequence s_enable_write;
        req_in.wr && hit_en;
    endsequence

    // Disable write arriving on the coupling port
    sequence s_disable_write;
        dis_in.wr;
    endsequence

    // Read of either offset that returns the enables
    sequence s_read_hit;
        req_in.rd && (hit_en || hit_dis);
    endsequence

    // Neither a set nor a clear in this cycle
    sequence s_enables_idle;
        !(req_in.wr && hit_en) && !dis_in.wr;
    endsequence

    property p_irq_needs_master;
        irq_out |-> $past(en_q[OIG_MASTER_BIT]) && $past(|(status_in & en_q & OIG_EVENT_MASK));
    endproperty
    a_irq_needs_master: assert property (p_irq_needs_master)    // see RULE1
        else $error("Interrupt raised without status, enable and master");

    property p_master_off;
        !en_q[OIG_MASTER_BIT] |=> !irq_out;
    endproperty
    a_master_off: assert property (p_master_off)                // see RULE5
        else $error("Interrupt raised with master gate off");

    property p_set_on_one;
        s_enable_write |=> ((en_q & $past(req_in.wdata & OIG_IMPL_MASK))
                            == $past(req_in.wdata & OIG_IMPL_MASK));
    endproperty
    a_set_on_one: assert property (p_set_on_one)                // see RULE2
        else $error("Written one did not set enable bit");

    property p_zero_keeps;
        (s_enable_write and !dis_in.wr) |=>
            en_q == ($past(en_q) | $past(req_in.wdata & OIG_IMPL_MASK));
    endproperty
    a_zero_keeps: assert property (p_zero_keeps)                // see RULE3
        else $error("Written zero changed an enable bit");

    property p_read_back;
        req_in.rd && hit_en |=> rdata_out == $past(en_q);
    endproperty
    a_read_back: assert property (p_read_back)                  // see RULE4
        else $error("Read did not return enable bits");

    property p_owner_irq;
        status_in[OIG_OWNER_BIT] && en_q[OIG_OWNER_BIT] && en_q[OIG_MASTER_BIT] |=> irq_out;
    endproperty
    a_owner_irq: assert property (p_owner_irq)                  // see RULE6
        else $error("Ownership change did not interrupt");

    property p_event_irq;
        (|(status_in[OIG_EVENT_TOP:0] & en_q[OIG_EVENT_TOP:0])) && en_q[OIG_MASTER_BIT]
            |=> irq_out;
    endproperty
    a_event_irq: assert property (p_event_irq)                  // see RULE7
        else $error("Enabled event did not interrupt");

    property p_disable_clears;
        dis_in.wr && !req_in.wr |=> (en_q & $past(dis_in.wdata & OIG_IMPL_MASK)) == 32'h0000_0000;
    endproperty
    a_disable_clears: assert property (p_disable_clears)        // see RULE11
        else $error("Disable write did not clear enable bit");

    property p_reserved_zero;
        (en_q & ~OIG_IMPL_MASK) == 32'h0000_0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)          // see RULE8
        else $error("Reserved enable bit became set");

    property p_level_drop;
        !(|(status_in & en_q & OIG_EVENT_MASK)) |=> !irq_out;
    endproperty
    a_level_drop: assert property (p_level_drop)                // see RULE12
        else $error("Interrupt held with no enabled flag");

    // Further checks on the register port and the gate
    property p_idle_holds;
        s_enables_idle |=> en_q == $past(en_q);
    endproperty
    a_idle_holds: assert property (p_idle_holds)                // see RULE3
        else $error("Enable bits changed without a write");

    property p_other_offset;
        req_in.wr && !hit_en && !dis_in.wr |=> en_q == $past(en_q);
    endproperty
    a_other_offset: assert property (p_other_offset)            // see RULE9
        else $error("Write to another offset changed the enables");

    property p_read_idle_zero;
        !(req_in.rd && (hit_en || hit_dis)) |=> rdata_out == 32'h0000_0000;
    endproperty
    a_read_idle_zero: assert property (p_read_idle_zero)        // see RULE9
        else $error("Read data not zero outside a register read");

    property p_read_either;
        s_read_hit |=> rdata_out == $past(en_q);
    endproperty
    a_read_either: assert property (p_read_either)              // see RULE4
        else $error("Read of an enable view returned wrong bits");

    property p_owner_off;
        status_in[OIG_OWNER_BIT] && (status_in[OIG_EVENT_TOP:0] == 7'h00)
            && !en_q[OIG_OWNER_BIT] |=> !irq_out;
    endproperty
    a_owner_off: assert property (p_owner_off)                  // see RULE6
        else $error("Masked ownership change raised the request");

    property p_event_off;
        !status_in[OIG_OWNER_BIT]
            && ((status_in[OIG_EVENT_TOP:0] & en_q[OIG_EVENT_TOP:0]) == 7'h00) |=> !irq_out;
    endproperty
    a_event_off: assert property (p_event_off)                  // see RULE7
        else $error("Masked frame event raised the request");

    property p_set_wins;
        (s_enable_write and s_disable_write) |=>
            ((en_q & $past(req_in.wdata & OIG_IMPL_MASK))
             == $past(req_in.wdata & OIG_IMPL_MASK));
    endproperty
    a_set_wins: assert property (p_set_wins)                    // see RULE2
        else $error("Clear in the same cycle beat a set");

endmodule // oig_enable_gate

// File: tb/oig_host_model.sv
/* Host driver model issuing register writes and reads.
   Assumes oig_pkg is compiled first and one clk_in domain. */
`timescale 1ns/10ps
module oig_host_model
    import oig_pkg::*;
(
    // Clock
    input  wire logic clk_in,
    // Register port
    output oig_req_t  req_out
);
    // Idle port at time zero
    initial req_out = '0;
    // One-cycle strobe, then released lines flip so stale data never matches
    task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in) #1;
        req_out = '{w, !w, a, d & OIG_IMPL_MASK};
        @(posedge clk_in) #1;
        req_out = '{1'b0, 1'b0, ~a, ~req_out.wdata};
    endtask
endmodule // oig_host_model

// File: tb/oig_enable_gate_test.sv
/* Self-checking bench for the enable gating stage.
   Assumes oig_pkg, the design and the host model are compiled first. */
`timescale 1ns/10ps
module oig_enable_gate_test;
    import oig_pkg::*;
    logic        clk_in = 1'b0;  // 250 MHz clock
    logic        rst_n_in = 1'b0; // Reset, active low
    oig_req_t    req;            // Host model request
    oig_dis_t    dis = '0;       // Disable coupling
    logic [31:0] status = '0;    // Event status flags
    logic [31:0] rdata, enable;  // Read data and enables
    logic        irq;            // Interrupt request
    int          errors = 0;     // Mismatch count
    int          n_checks = 0;   // Comparison count
    int          bits[9] = '{0, 1, 2, 3, 4, 5, 6, 30, 31}; // Flag positions
    always #2 clk_in = ~clk_in;
    oig_host_model host (.clk_in(clk_in), .req_out(req));
    oig_enable_gate uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req),
        .rdata_out(rdata), .status_in(status), .dis_in(dis),
        .enable_out(enable), .irq_out(irq));
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Wait n edges, then settle
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // Sweep single flags, irq expected only where enabled and gated
    task automatic sweep(input logic [31:0] en);
        foreach (bits[i]) begin
            status = 32'h1 << bits[i];
            tick(2);
            check(irq, en[31] && en[bits[i]] && (bits[i] != 31));
        end
        status = '0;
        tick(2);
        check(irq, 1'b0);
    endtask
    // Closing report
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk_in);
        #1 rst_n_in = 1'b1;
        check(enable, OIG_ENABLE_RST);
        host.access(1'b0, 8'h10, '0);
        check(rdata, 32'h0);
        host.access(1'b1, 8'h10, 32'h0000_0004);
        status = 32'h4;
        tick(2);
        check(irq, 1'b0);
        host.access(1'b1, 8'h10, 32'h8000_0000);
        check(enable, 32'h8000_0004);
        tick(1);
        check(irq, 1'b1);
        sweep(32'h8000_0004);
        host.access(1'b1, 8'h10, 32'h4000_007F);
        check(enable, 32'hC000_007F);
        sweep(32'hC000_007F);
        @(posedge clk_in) #1 dis = '{1'b1, 32'h4000_0001};
        @(posedge clk_in) #1 dis = '0;
        check(enable, 32'h8000_007E);
        // Ones written to another offset must not set anything
        host.access(1'b1, 8'h18, 32'h4000_0001);
        check(enable, 32'h8000_007E);
        sweep(32'h8000_007E);
        host.access(1'b0, 8'h14, '0);
        check(rdata, 32'h8000_007E);
        tick(1);
        check(rdata, 32'h0);
        host.access(1'b0, 8'h0C, '0);
        check(rdata, 32'h0);
        // Set and clear of one bit in the same cycle: set kept
        fork
            host.access(1'b1, 8'h10, 32'h0000_0001);
            begin
                @(posedge clk_in) #1 dis = '{1'b1, 32'h0000_0001};
                @(posedge clk_in) #1 dis = '0;
            end
        join
        check(enable, 32'h8000_007F);
        // Held flag keeps the request up
        status = 32'h0000_0001;
        tick(5);
        check(irq, 1'b1);
        // Reset in mid-run clears enables and request
        rst_n_in = 1'b0;
        tick(2);
        check(enable, OIG_ENABLE_RST);
        check(irq, 1'b0);
        rst_n_in = 1'b1;
        tick(2);
        check(irq, 1'b0);
        status = '0;
        print_verdict();
    end
endmodule // oig_enable_gate_test
